//--- include/chip_select_pkg.sv
// Contract
// - five separate select outputs: code, data flash, sram, uart, status area
// - boot jumper closed enables all five select outputs
// - window and bus control registers are writable at any time
// - jumper open after reset: whole space goes to code select only
// - first external read after reset is at address zero on code select
// - each bus control register holds bus type and timing of its window
// - every wait state lengthens the strobe phase by 50 ns
// - every turnaround period adds 50 ns after the strobe
// - zero waits, 16-bit demultiplexed: cycle takes 100 ns
// - one wait with strobe delay: cycle takes 150 ns
// - code window starts as 16-bit demultiplexed without software
// - window size code 0110 gives a 256 kByte window
// - read timing bit clear: select asserts before the read strobe
// - write timing bit clear: select asserts before the write strobe
package chip_select_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_BASE_NS     = 100;
    localparam int T_SETUP_NS    = 35;
    localparam int T_DELAY_NS    = 25;
    localparam int T_WAIT_NS     = 50;
    localparam int T_TURN_NS     = 50;
    localparam int BASE_CYC      = (T_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_DLY_CYC =
        (T_SETUP_NS + T_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC      = (T_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC      = (T_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // bus control fields
    localparam int F_WAIT_LO = 0;
    localparam int F_DELAY   = 4;
    localparam int F_TURN    = 5;
    localparam int F_TYPE_LO = 6;
    localparam int F_LATCH   = 9;
    localparam int F_ACTIVE  = 10;
    localparam int F_READY   = 12;
    localparam int F_CS_RD   = 14;
    localparam int F_CS_WR   = 15;
    // window select fields
    localparam int F_SIZE_LO = 0;
    localparam int F_BASE_LO = 4;

    localparam logic [1:0] BT_8_DEMUX  = 2'h0;
    localparam logic [1:0] BT_16_DEMUX = 2'h2;

    localparam logic [15:0] WIN_RESET   = 16'h0000;
    localparam logic [15:0] CTL_RESET   = 16'h0000;
    localparam logic [15:0] CTL0_BOOT   = 16'h0480;
    localparam logic [4:0]  SEL_EN_OPEN = 5'h01;
    localparam logic [4:0]  SEL_EN_BOOT = 5'h1f;
    localparam logic [23:0] BOOT_ADDR   = 24'h00_0000;

    localparam logic [7:0] OFS_WIN0   = 8'h00;
    localparam logic [7:0] OFS_CTL0   = 8'h04;
    localparam logic [7:0] OFS_STRIDE = 8'h08;
    localparam logic [7:0] OFS_SEL_EN = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_BOOT   = 8'h30;
    localparam int         ST_UNMAP   = 5;

    typedef enum logic [2:0] {
        S_BOOT   = 3'h4,
        S_IDLE   = 3'h0,
        S_SETUP  = 3'h1,
        S_STROBE = 3'h3,
        S_TURN   = 3'h2
    } state_t;

    function automatic logic window_hit(input logic [11:0] page, input logic [15:0] win);
        logic [11:0] mask;
        mask = 12'hfff << win[F_SIZE_LO +: 4];
        return ((page ^ win[F_BASE_LO +: 12]) & mask) == 12'h000;
    endfunction

    function automatic logic [3:0] wait_count(input logic [15:0] ctl);
        return ~ctl[F_WAIT_LO +: 4];
    endfunction
endpackage

//--- rtl/window_decode.sv
`timescale 1ns/1ps
`default_nettype none
module window_decode (
    input  wire logic [11:0]      page,
    input  wire logic [4:0][15:0] win,
    input  wire logic [4:0]       active,
    input  wire logic [4:0]       sel_en,
    input  wire logic             win0_set,
    output logic                  hit,
    output logic [2:0]            index
);
    always_comb begin
        hit   = 1'b0;
        index = 3'h0;
        // lowest numbered matching window of 1 to 4 wins; code window 0 only when none of them match
        for (int i = 4; i >= 1; i--) begin
            if (active[i] && sel_en[i] && chip_select_pkg::window_hit(page, win[i])) begin
                hit   = 1'b1;
                index = 3'(i);
            end
        end
        if (!hit && sel_en[0]) begin
            // unprogrammed code window catches the whole space
            hit = !win0_set || chip_select_pkg::window_hit(page, win[0]);
        end
    end
endmodule
`default_nettype wire

//--- rtl/phase_counter.sv
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done = (count == '0);
endmodule
`default_nettype wire

//--- rtl/external_bus_chip_select_unit.sv
`timescale 1ns/1ps
`default_nettype none
module external_bus_chip_select_unit (
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        REQ,
    input  wire logic [23:0] REQ_ADDR,
    input  wire logic        REQ_WRITE,
    input  wire logic [15:0] REQ_WDATA,
    output logic             REQ_ACK,
    output logic [15:0]      REQ_RDATA,
    input  wire logic        BOOT_JUMPER,
    output logic             CODE_SELECT_N,
    output logic             DATAFLASH_SELECT_N,
    output logic             SRAM_SELECT_N,
    output logic             UART_SELECT_N,
    output logic             STATUS_AREA_SELECT_N,
    output logic [23:0]      EXT_ADDR,
    output logic             EXT_RD_N,
    output logic             EXT_WR_N,
    output logic             EXT_WIDE,
    input  wire logic [15:0] EXT_DATA_I,
    output logic [15:0]      EXT_DATA_O,
    output logic             EXT_DATA_OE
);
    logic [4:0][15:0]             win;
    logic [4:0][15:0]             ctl;
    logic [4:0]                   sel_en;
    logic                         win0_set;
    logic                         jumper_closed;
    logic                         boot_done;
    logic                         unmapped;
    logic [15:0]                  boot_word;
    logic [1:0]                   jumper_sync;
    logic [15:0]                  data_sync0;
    logic [15:0]                  data_sync1;
    logic [1:0]                   settle;
    chip_select_pkg::state_t      state;
    chip_select_pkg::state_t      next_state;
    logic [2:0]                   cur;
    logic [15:0]                  cur_ctl;
    logic [23:0]                  cur_addr;
    logic                         cur_we;
    logic [15:0]                  cur_wdata;
    logic                         cur_boot;
    logic                         dec_hit;
    logic [2:0]                   dec_index;
    logic [4:0]                   active;
    logic                         load;
    logic [7:0]                   load_value;
    logic                         phase_done;
    logic                         launch;
    logic                         wb_req;
    logic                         wb_wr;
    logic [31:0]                  rd_mux;
    logic                         early;
    logic [4:0]                   next_sel_n;
    logic [15:0]                  ext_rdata;
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction
    function automatic logic [7:0] strobe_len(input logic [15:0] c);
        logic [7:0] setup;
        setup = c[chip_select_pkg::F_DELAY] ? 8'(chip_select_pkg::SETUP_CYC)
                                            : 8'(chip_select_pkg::SETUP_DLY_CYC);
        // base cycle less setup, plus one wait period per wait state
        return 8'(chip_select_pkg::BASE_CYC) - setup
             + 8'(chip_select_pkg::wait_count(c)) * 8'(chip_select_pkg::WAIT_CYC);
    endfunction
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            active[i] = ctl[i][chip_select_pkg::F_ACTIVE];
        end
    end
    window_decode u_decode (
        .page     (REQ_ADDR[23:12]),
        .win      (win),
        .active   (active),
        .sel_en   (sel_en),
        .win0_set (win0_set),
        .hit      (dec_hit),
        .index    (dec_index)
    );
    phase_counter #(.WIDTH(8)) u_phase (
        .clk        (SYS_CLK),
        .rst        (SYS_RST),
        .load       (load),
        .load_value (load_value),
        .done       (phase_done)
    );
    // pin inputs pass two flip-flops
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            jumper_sync <= 2'h0;
            data_sync0  <= 16'h0000;
            data_sync1  <= 16'h0000;
        end else begin
            jumper_sync <= {jumper_sync[0], BOOT_JUMPER};
            data_sync0  <= EXT_DATA_I;
            data_sync1  <= data_sync0;
        end
    end
    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wb_wr  = wb_req && WB_WE_I;
    assign launch = (state == chip_select_pkg::S_IDLE) && REQ && !REQ_ACK;
    // register file, writable at any time
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            win      <= {5{chip_select_pkg::WIN_RESET}};
            ctl      <= {{4{chip_select_pkg::CTL_RESET}}, chip_select_pkg::CTL0_BOOT};
            win0_set <= 1'b0;
        end else if (wb_wr) begin
            for (int i = 0; i < 5; i++) begin
                if (WB_ADR_I == 8'(chip_select_pkg::OFS_WIN0 + i * chip_select_pkg::OFS_STRIDE)) begin
                    win[i] <= merge16(win[i], WB_DAT_I, WB_SEL_I);
                    if (i == 0) begin
                        win0_set <= 1'b1;
                    end
                end
                if (WB_ADR_I == 8'(chip_select_pkg::OFS_CTL0 + i * chip_select_pkg::OFS_STRIDE)) begin
                    ctl[i] <= merge16(ctl[i], WB_DAT_I, WB_SEL_I);
                end
            end
        end
    end
    // select enables caught from the jumper once the synchroniser has settled
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sel_en        <= chip_select_pkg::SEL_EN_OPEN;
            jumper_closed <= 1'b0;
        end else if (state == chip_select_pkg::S_BOOT && settle[1]) begin
            jumper_closed <= jumper_sync[1];
            sel_en        <= jumper_sync[1] ? chip_select_pkg::SEL_EN_BOOT
                                            : chip_select_pkg::SEL_EN_OPEN;
        end else if (wb_wr && WB_ADR_I == chip_select_pkg::OFS_SEL_EN && WB_SEL_I[0]) begin
            sel_en <= WB_DAT_I[4:0];
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            unmapped <= 1'b0;
        end else if (launch && !dec_hit) begin
            unmapped <= 1'b1;
        end else if (wb_wr && WB_ADR_I == chip_select_pkg::OFS_STATUS && WB_SEL_I[0]
                     && WB_DAT_I[chip_select_pkg::ST_UNMAP]) begin
            unmapped <= 1'b0;
        end
    end
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < 5; i++) begin
            if (WB_ADR_I == 8'(chip_select_pkg::OFS_WIN0 + i * chip_select_pkg::OFS_STRIDE)) begin
                rd_mux = {16'h0000, win[i]};
            end
            if (WB_ADR_I == 8'(chip_select_pkg::OFS_CTL0 + i * chip_select_pkg::OFS_STRIDE)) begin
                rd_mux = {16'h0000, ctl[i]};
            end
        end
        if (WB_ADR_I == chip_select_pkg::OFS_SEL_EN) begin
            rd_mux = {27'h000_0000, sel_en};
        end
        if (WB_ADR_I == chip_select_pkg::OFS_STATUS) begin
            rd_mux = {24'h00_0000, (state != chip_select_pkg::S_IDLE), boot_done, unmapped,
                      jumper_closed, win0_set, cur};
        end
        if (WB_ADR_I == chip_select_pkg::OFS_BOOT) begin
            rd_mux = {16'h0000, boot_word};
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            if (wb_req) begin
                WB_DAT_O <= rd_mux;
            end
        end
    end
    // access sequencing
    always_comb begin
        next_state = state;
        load       = 1'b0;
        load_value = 8'h00;
        case (state)
            chip_select_pkg::S_BOOT: begin
                if (settle[1]) begin
                    next_state = chip_select_pkg::S_SETUP;
                    load       = 1'b1;
                    load_value = 8'(chip_select_pkg::SETUP_DLY_CYC - 1);
                end
            end
            chip_select_pkg::S_IDLE: begin
                if (launch && dec_hit) begin
                    next_state = chip_select_pkg::S_SETUP;
                    load       = 1'b1;
                    load_value = ctl[dec_index][chip_select_pkg::F_DELAY]
                               ? 8'(chip_select_pkg::SETUP_CYC - 1)
                               : 8'(chip_select_pkg::SETUP_DLY_CYC - 1);
                end
            end
            chip_select_pkg::S_SETUP: begin
                if (phase_done) begin
                    next_state = chip_select_pkg::S_STROBE;
                    load       = 1'b1;
                    load_value = strobe_len(cur_ctl) - 8'h01;
                end
            end
            chip_select_pkg::S_STROBE: begin
                if (phase_done) begin
                    if (!cur_ctl[chip_select_pkg::F_TURN]) begin
                        next_state = chip_select_pkg::S_TURN;
                        load       = 1'b1;
                        load_value = 8'(chip_select_pkg::TURN_CYC - 1);
                    end else begin
                        next_state = chip_select_pkg::S_IDLE;
                    end
                end
            end
            chip_select_pkg::S_TURN: begin
                if (phase_done) begin
                    next_state = chip_select_pkg::S_IDLE;
                end
            end
            default: begin
                next_state = chip_select_pkg::S_IDLE;
            end
        endcase
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state  <= chip_select_pkg::S_BOOT;
            settle <= 2'h0;
        end else begin
            state  <= next_state;
            settle <= {settle[0], 1'b1};
        end
    end
    // access latched at launch so register writes cannot disturb it
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cur       <= 3'h0;
            cur_ctl   <= chip_select_pkg::CTL0_BOOT;
            cur_addr  <= chip_select_pkg::BOOT_ADDR;
            cur_we    <= 1'b0;
            cur_wdata <= 16'h0000;
            cur_boot  <= 1'b1;
        end else if (launch && dec_hit) begin
            cur       <= dec_index;
            cur_ctl   <= ctl[dec_index];
            cur_addr  <= REQ_ADDR;
            cur_we    <= REQ_WRITE;
            cur_wdata <= REQ_WDATA;
            cur_boot  <= 1'b0;
        end
    end
    assign ext_rdata = (cur_ctl[chip_select_pkg::F_TYPE_LO +: 2] == chip_select_pkg::BT_16_DEMUX)
                     ? data_sync1 : {8'h00, data_sync1[7:0]};
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            boot_done <= 1'b0;
            boot_word <= 16'h0000;
            REQ_ACK   <= 1'b0;
            REQ_RDATA <= 16'h0000;
        end else begin
            REQ_ACK <= 1'b0;
            if (state == chip_select_pkg::S_STROBE && phase_done && !cur_we) begin
                if (cur_boot) begin
                    boot_word <= ext_rdata;
                end else begin
                    REQ_RDATA <= ext_rdata;
                end
            end
            if (launch && !dec_hit) begin
                REQ_ACK   <= 1'b1;
                REQ_RDATA <= 16'h0000;
            end
            if (next_state == chip_select_pkg::S_IDLE && state != chip_select_pkg::S_IDLE) begin
                if (cur_boot) begin
                    boot_done <= 1'b1;
                end else begin
                    REQ_ACK <= 1'b1;
                end
            end
        end
    end

    // pins follow the sequencer one cycle later
    assign early = !(cur_we ? cur_ctl[chip_select_pkg::F_CS_WR] : cur_ctl[chip_select_pkg::F_CS_RD]);

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            next_sel_n[i] = !((cur == 3'(i)) && ((state == chip_select_pkg::S_STROBE)
                          || (state == chip_select_pkg::S_SETUP && early)));
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CODE_SELECT_N        <= 1'b1;
            DATAFLASH_SELECT_N   <= 1'b1;
            SRAM_SELECT_N        <= 1'b1;
            UART_SELECT_N        <= 1'b1;
            STATUS_AREA_SELECT_N <= 1'b1;
            EXT_ADDR             <= 24'h00_0000;
            EXT_RD_N             <= 1'b1;
            EXT_WR_N             <= 1'b1;
            EXT_WIDE             <= 1'b1;
            EXT_DATA_O           <= 16'h0000;
            EXT_DATA_OE          <= 1'b0;
        end else begin
            CODE_SELECT_N        <= next_sel_n[0];
            DATAFLASH_SELECT_N   <= next_sel_n[1];
            SRAM_SELECT_N        <= next_sel_n[2];
            UART_SELECT_N        <= next_sel_n[3];
            STATUS_AREA_SELECT_N <= next_sel_n[4];
            EXT_ADDR             <= cur_addr;
            EXT_RD_N             <= !(state == chip_select_pkg::S_STROBE && !cur_we);
            EXT_WR_N             <= !(state == chip_select_pkg::S_STROBE && cur_we);
            EXT_WIDE             <= cur_ctl[chip_select_pkg::F_TYPE_LO +: 2]
                                    == chip_select_pkg::BT_16_DEMUX;
            EXT_DATA_O           <= cur_wdata;
            EXT_DATA_OE          <= cur_we && (state == chip_select_pkg::S_SETUP
                                    || state == chip_select_pkg::S_STROBE);
        end
    end
endmodule
`default_nettype wire

//--- testbench/chip_select_props.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_props (
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic        REQ_ACK,
    input wire logic        CODE_SELECT_N,
    input wire logic        DATAFLASH_SELECT_N,
    input wire logic        SRAM_SELECT_N,
    input wire logic        UART_SELECT_N,
    input wire logic        STATUS_AREA_SELECT_N,
    input wire logic [23:0] EXT_ADDR,
    input wire logic        EXT_RD_N,
    input wire logic        EXT_WR_N
);
    logic [4:0] sel_n;
    logic       seen;
    assign sel_n = {STATUS_AREA_SELECT_N, UART_SELECT_N, SRAM_SELECT_N,
                    DATAFLASH_SELECT_N, CODE_SELECT_N};
    // marks the first external access after each reset
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            seen <= 1'b0;
        end else if (sel_n != 5'h1f) begin
            seen <= 1'b1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    a_wb_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("register ack late");
    a_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("register ack too long");
    a_req_ack_pulse: assert property (REQ_ACK |=> !REQ_ACK)
        else $error("access ack too long");
    a_one_select: assert property ($countones(~sel_n) <= 1)
        else $error("two selects low");
    a_cs_before_rd: assert property ($fell(EXT_RD_N) |-> !$past(&sel_n))
        else $error("select not ahead of read strobe");
    a_cs_before_wr: assert property ($fell(EXT_WR_N) |-> !$past(&sel_n))
        else $error("select not ahead of write strobe");
    a_strobe_min: assert property ($fell(EXT_RD_N) |-> !EXT_RD_N [*8])
        else $error("read strobe too short");
    a_boot_first: assert property (!seen && sel_n != 5'h1f |->
        sel_n == 5'h1e && EXT_ADDR == 24'h00_0000)
        else $error("first access not code at zero");
    a_strobes_apart: assert property (EXT_RD_N || EXT_WR_N)
        else $error("both strobes low");
    cover property ($fell(EXT_WR_N));
    cover property ($fell(EXT_RD_N) && !SRAM_SELECT_N);
    cover property (!UART_SELECT_N && !EXT_RD_N);
endmodule
bind external_bus_chip_select_unit chip_select_props u_props (.SYS_CLK, .SYS_RST,
    .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .REQ_ACK, .CODE_SELECT_N, .DATAFLASH_SELECT_N,
    .SRAM_SELECT_N, .UART_SELECT_N, .STATUS_AREA_SELECT_N, .EXT_ADDR, .EXT_RD_N,
    .EXT_WR_N);
`default_nettype wire

//--- testbench/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input wire logic        clk,
    input wire logic [4:0]  sel_n,
    input wire logic [23:0] addr,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        oe,
    input wire logic [15:0] din,
    output logic [15:0]     dout
);
    logic [15:0] m [0:15];
    logic [4:0]  hit;
    int          cnt;
    int          slen;
    initial begin
        for (int i = 0; i < 16; i++) begin
            m[i] = 16'ha5a0 + 16'(i);
        end
        dout = 16'h0000;
        cnt = 0;
    end
    always @(posedge clk) begin
        // an idle bus shows a changing pattern, the previous value inverted on every edge
        dout <= (!rd_n && sel_n != 5'h1f) ? m[addr[4:1]] : ~dout;
        if (!wr_n && oe && sel_n != 5'h1f) begin
            m[addr[4:1]] <= din;
        end
        if (!rd_n || !wr_n) begin
            cnt <= cnt + 1;
            hit <= ~sel_n;
        end else if (cnt != 0) begin
            slen <= cnt;
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst, cyc, stb, we, req, rwr, jmp, ack, rack, rdn, wrn, wide, oe;
    logic [7:0]  adr, o;
    logic [31:0] wdat, dat_o;
    logic [23:0] raddr, ea;
    logic [15:0] rwdat, rdata, rq, wb_q, edo, edi;
    logic [4:0]  sel_n;
    int          num_errors, n_tests, k;
    external_bus_chip_select_unit dut (.SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .REQ(req), .REQ_ADDR(raddr), .REQ_WRITE(rwr),
        .REQ_WDATA(rwdat), .REQ_ACK(rack), .REQ_RDATA(rdata), .BOOT_JUMPER(jmp),
        .CODE_SELECT_N(sel_n[0]), .DATAFLASH_SELECT_N(sel_n[1]), .SRAM_SELECT_N(sel_n[2]),
        .UART_SELECT_N(sel_n[3]), .STATUS_AREA_SELECT_N(sel_n[4]), .EXT_ADDR(ea),
        .EXT_RD_N(rdn), .EXT_WR_N(wrn), .EXT_WIDE(wide), .EXT_DATA_I(edi),
        .EXT_DATA_O(edo), .EXT_DATA_OE(oe));
    ext_mem_model mem (.clk(clk), .sel_n(sel_n), .addr(ea), .rd_n(rdn), .wr_n(wrn),
        .oe(oe), .din(edo), .dout(edi));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        wb_q = dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n == 50) chk("reg ack", 0, 1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        chk("register", 32'(wb_q), 32'(e));
    endtask
    task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
        req <= 1'b1;
        rwr <= w;
        raddr <= a;
        rwdat <= d;
        k = 0;
        do begin @(posedge clk); k++; end while (rack !== 1'b1 && k < 2000);
        rq = rdata;
        req <= 1'b0;
        // second edge lets the model publish its strobe count
        repeat (2) @(posedge clk);
        if (k == 2000) chk("access ack", 0, 1);
    endtask
    task automatic do_reset(input logic j);
        int n;
        jmp <= j;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        do begin wb(1'b0, 8'h2c, 16'h0000); n++; end while (wb_q[6] !== 1'b1 && n < 200);
        chk("boot done", 32'(wb_q[6]), 1);
    endtask
    task automatic t_open;
        chk("boot hit", 32'(mem.hit), 1);
        rchk(8'h28, 16'h0001);
        rchk(8'h04, 16'h0480);
        rchk(8'h30, 16'ha5a0);
        chk("boot wide", 32'(wide), 1);
        wb(1'b1, 8'h10, 16'h1008);
        wb(1'b1, 8'h14, 16'h04af);
        acc(1'b0, 24'h10_0010, 16'h0000);
        chk("open hit", 32'(mem.hit), 1);
        chk("open data", 32'(rq), 32'h0000_a5a8);
    endtask
    task automatic t_windows;
        logic [15:0] wv [4] = '{16'h2006, 16'h1008, 16'hffe0, 16'hfff0};
        logic [15:0] cv [4] = '{16'h04af, 16'h04af, 16'h040d, 16'h040d};
        logic [23:0] av [4] = '{24'h23_fffe, 24'h10_0010, 24'hff_e004, 24'hff_f002};
        logic [15:0] ev [4] = '{16'ha5af, 16'ha5a8, 16'h00a2, 16'h00a1};
        rchk(8'h28, 16'h001f);
        wb(1'b1, 8'h00, 16'h0008);
        for (int i = 0; i < 4; i++) begin
            o = 8'(8 * (i + 1));
            wb(1'b1, o, wv[i]);
            wb(1'b1, o + 8'h04, cv[i]);
            rchk(o, wv[i]);
            rchk(o + 8'h04, cv[i]);
            acc(1'b0, av[i], 16'h0000);
            chk("window hit", 32'(mem.hit), 32'(5'h02 << i));
            chk("window data", 32'(rq), 32'(ev[i]));
            chk("window wide", 32'(wide), 32'(i < 2));
        end
    endtask
    task automatic t_timing;
        logic [15:0] cv [3] = '{16'h04af, 16'h04ae, 16'h048f};
        int          kv [3] = '{27, 40, 40};
        int          lv [3] = '{10, 23, 10};
        acc(1'b1, 24'h10_0010, 16'h1234);
        chk("write hit", 32'(mem.hit), 4);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, 8'h14, cv[i]);
            acc(1'b0, 24'h10_0010, 16'h0000);
            chk("cycles", 32'(k), 32'(kv[i]));
            chk("strobe", 32'(mem.slen), 32'(lv[i]));
            chk("sram data", 32'(rq), 32'h0000_1234);
        end
    endtask
    task automatic t_unmap;
        acc(1'b0, 24'h24_0000, 16'h0000);
        chk("unmapped cycles", 32'(k), 2);
        chk("unmapped data", 32'(rq), 0);
        wb(1'b0, 8'h2c, 16'h0000);
        chk("unmapped flag", 32'(wb_q[5]), 1);
        wb(1'b1, 8'h2c, 16'h0020);
        wb(1'b0, 8'h2c, 16'h0000);
        chk("flag clear", 32'(wb_q[5]), 0);
        wb(1'b1, 8'h3c, 16'hffff);
        rchk(8'h3c, 16'h0000);
    endtask
    task automatic summarize;
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        {rst, cyc, stb, we, req, rwr, jmp} = 7'h40;
        {adr, wdat, raddr, rwdat} = '0;
        do_reset(1'b0);
        t_open();
        do_reset(1'b1);
        t_windows();
        t_timing();
        t_unmap();
        summarize();
    end
endmodule
`default_nettype wire
